// [include/budget_pkg.sv]
// Package with offsets, field layouts, reset values and carrier types of the budget registers.
`default_nettype none
package budget_pkg;

  // ==========================================================================
  // Register byte offsets (low twelve address bits).
  localparam logic [11:0] OFFSET_HEADER      = 12'h280;
  localparam logic [11:0] OFFSET_SELECT      = 12'h284;
  localparam logic [11:0] OFFSET_READBACK    = 12'h288;
  localparam logic [11:0] OFFSET_FLAGS       = 12'h28C;
  localparam logic [11:0] OFFSET_SYS_CONTROL = 12'h290;
  localparam logic [11:0] OFFSET_VALUE_BASE  = 12'h300;

  // ==========================================================================
  // Entry bank geometry.
  localparam int          VALUE_COUNT      = 10;
  localparam logic [7:0]  VALUE_LAST_INDEX = 8'h09;
  localparam logic [9:0]  VALUE_WORDS      = 10'h00A;

  // ==========================================================================
  // Field positions and widths.
  localparam int SELECT_WIDTH   = 8;
  localparam int FLAG_SA_BIT    = 0;
  localparam int UNLOCK_BIT     = 0;
  localparam int HTRANS_ACTIVE  = 1;

  // ==========================================================================
  // Reset values and identifying contents.
  localparam logic [31:0] HEADER_RESET      = 32'h0000_0000;
  localparam logic [7:0]  SELECT_RESET      = 8'h00;
  localparam logic        FLAG_RESET        = 1'b0;
  localparam logic        UNLOCK_RESET      = 1'b0;
  localparam logic [31:0] VALUE_RESET       = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO         = 32'h0000_0000;
  localparam logic [15:0] CAP_ID_POWER      = 16'h0004;
  localparam logic [3:0]  CAP_VERSION_ONE   = 4'h1;
  localparam logic [1:0]  HRESP_OKAY        = 2'h0;

  // ==========================================================================
  // Carrier types.
  typedef struct packed {
    logic [11:0] next_capability_link;
    logic [3:0]  capability_version_field;
    logic [15:0] capability_identifier;
  } header_type;

  typedef struct packed {
    logic        en;
    logic        lock_bypass;
    logic [11:0] offset;
    logic [31:0] data;
  } reg_write_type;

  typedef struct packed {
    logic        en;
    logic [3:0]  index;
    logic [31:0] data;
  } value_write_type;

endpackage : budget_pkg
`default_nettype wire

// [logic/budget_value_bank.sv]
// Ten sticky power data value words with the indexed read-back selector.
`default_nettype none
module budget_value_bank
  import budget_pkg::*;
(
  input  wire logic                    clk_sys_in,
  input  wire logic                    resetn_in,
  input  wire value_write_type         write_in,
  input  wire logic [SELECT_WIDTH-1:0] select_in,
  output logic      [31:0]             readback_out
);

  logic [31:0] value_q [VALUE_COUNT];

  // ==========================================================================
  // Storage.
  // Only the fundamental reset clears the words; a hot reset leaves them.
  // The cleared value is a choice, software must not rely on it.
  genvar g;
  generate
    for (g = 0; g < VALUE_COUNT; g++)
    begin : g_entry
      wire logic hit = write_in.en && (write_in.index == 4'(g));
      always_ff @(posedge clk_sys_in)
      begin
        if (!resetn_in)
          value_q[g] <= VALUE_RESET;
        else if (hit)
          value_q[g] <= write_in.data;
      end
    end
  endgenerate

  // ==========================================================================
  // Read-back selection.
  wire logic in_range = (select_in <= VALUE_LAST_INDEX);
  assign readback_out = in_range ? value_q[select_in[3:0]] : READ_ZERO;

endmodule : budget_value_bank
`default_nettype wire

// [logic/power_budget_capability_regs.sv]
// Power budgeting capability register bank behind an AHB-Lite slave port.
//
// What this block does
// - The low sixteen header bits hold the capability identifier, where 0x4 names power budgeting.
// - Header bits 19:16 hold the capability version, where 0x1 means version one.
// - Header fields clear at reset and can be loaded from serial configuration memory at start.
// - An eight-bit read-write entry select, cleared at reset, picks the word shown in read-back.
// - A select value above nine makes the read-back return zero.
// - The read-only read-back returns the chosen data value word, and zero beyond nine.
// - Flag bit zero is a sticky lock-writable system allocated bit, cleared at reset.
// - The ten data value words are 32-bit sticky storage holding budget data.
// - Lock-writable fields take bus writes only while the unlock bit of system control is set.
`default_nettype none
module power_budget_capability_regs
  import budget_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire logic        hot_reset_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  input  wire logic        serial_load_valid_in,
  input  wire logic [11:0] serial_load_offset_in,
  input  wire logic [31:0] serial_load_data_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic      [1:0]  hresp_out,
  output logic             system_allocated_out,
  output logic             capability_present_out
);

  // ==========================================================================
  // Register state.
  header_type              header_q;
  logic [SELECT_WIDTH-1:0] select_q;
  logic                    allocated_q;
  logic                    unlock_q;
  logic                    wr_pend_q;
  logic [11:0]             wr_offset_q;
  logic [31:0]             hrdata_q;
  logic                    present_q;
  logic [31:0]             readback;

  // ==========================================================================
  // Address phase decode.
  // Every transfer completes with no wait state, so hready stays high.
  // The size is not checked: only whole-word single transfers are expected.
  wire logic [2:0]  unused_size = hsize_in;
  wire logic        addr_phase  = hsel_in && htrans_in[HTRANS_ACTIVE] && hready_in;
  wire logic        rd_take     = addr_phase && !hwrite_in;
  wire logic        wr_take     = addr_phase && hwrite_in;
  wire logic [11:0] rd_offset   = haddr_in[11:0];

  // ==========================================================================
  // Write source selection.
  // A serial load wins over a bus write in the same cycle; it only happens
  // during initialisation, when software should not be writing anyway.
  wire reg_write_type bus_write  = '{en: wr_pend_q, lock_bypass: 1'b0,
                                     offset: wr_offset_q, data: hwdata_in};
  wire reg_write_type load_write = '{en: serial_load_valid_in, lock_bypass: 1'b1,
                                     offset: serial_load_offset_in,
                                     data: serial_load_data_in};
  wire reg_write_type wr = serial_load_valid_in ? load_write : bus_write;

  // Lock-writable targets need the unlock bit, except for the serial load.
  wire logic        wr_unlocked = wr.lock_bypass || unlock_q;
  wire logic [11:0] wr_rel      = wr.offset - OFFSET_VALUE_BASE;
  wire logic        wr_value_hit = (wr.offset >= OFFSET_VALUE_BASE) &&
                                   (wr_rel[11:2] < VALUE_WORDS) &&
                                   (wr_rel[1:0] == 2'h0);

  wire logic wr_header = wr.en && wr_unlocked && (wr.offset == OFFSET_HEADER);
  wire logic wr_select = wr.en && (wr.offset == OFFSET_SELECT);
  wire logic wr_flags  = wr.en && wr_unlocked && (wr.offset == OFFSET_FLAGS);
  wire logic wr_system_control_reg = wr.en && (wr.offset == OFFSET_SYS_CONTROL);
  wire logic wr_value  = wr.en && wr_unlocked && wr_value_hit;

  wire value_write_type value_write = '{en: wr_value, index: wr_rel[5:2], data: wr.data};

  // ==========================================================================
  // Read mux, sampled at the address phase edge.
  wire logic [11:0] rd_rel      = rd_offset - OFFSET_VALUE_BASE;
  wire logic        rd_value_hit = (rd_offset >= OFFSET_VALUE_BASE) &&
                                   (rd_rel[11:2] < VALUE_WORDS) &&
                                   (rd_rel[1:0] == 2'h0);
  wire logic [31:0] rd_flags  = {31'h0000_0000, allocated_q};
  wire logic [31:0] rd_system_control_reg = {31'h0000_0000, unlock_q};
  wire logic [31:0] rd_select = {24'h00_0000, select_q};
  logic [31:0] rd_value;

  // Data value words read back only through the selector; direct reads of the
  // word window return zero, which keeps a single read path into the bank.
  assign rd_value = READ_ZERO;

  wire logic [31:0] rd_data =
    (rd_offset == OFFSET_HEADER)      ? header_q  :
    (rd_offset == OFFSET_SELECT)      ? rd_select :
    (rd_offset == OFFSET_READBACK)    ? readback  :
    (rd_offset == OFFSET_FLAGS)       ? rd_flags  :
    (rd_offset == OFFSET_SYS_CONTROL) ? rd_system_control_reg :
    rd_value_hit                      ? rd_value  :
    READ_ZERO;

  wire logic present_d = (header_q.capability_identifier == CAP_ID_POWER) &&
                         (header_q.capability_version_field == CAP_VERSION_ONE);

  // ==========================================================================
  // Bus slave pipeline.
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      wr_pend_q   <= 1'b0;
      wr_offset_q <= 12'h000;
      hrdata_q    <= READ_ZERO;
    end
    else
    begin
      wr_pend_q <= wr_take;
      if (wr_take)
        wr_offset_q <= rd_offset;
      if (rd_take)
        hrdata_q <= rd_data;
    end
  end

  // ==========================================================================
  // Non-sticky registers: cleared by fundamental and hot reset.
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in || hot_reset_in)
    begin
      header_q <= HEADER_RESET;
      select_q <= SELECT_RESET;
      unlock_q <= UNLOCK_RESET;
    end
    else
    begin
      if (wr_header)
        header_q <= wr.data;
      if (wr_select)
        select_q <= wr.data[SELECT_WIDTH-1:0];
      if (wr_system_control_reg)
        unlock_q <= wr.data[UNLOCK_BIT];
    end
  end

  // ==========================================================================
  // Sticky flag: only the fundamental reset clears it.
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      allocated_q <= FLAG_RESET;
      present_q   <= 1'b0;
    end
    else
    begin
      if (wr_flags)
        allocated_q <= wr.data[FLAG_SA_BIT];
      present_q <= present_d;
    end
  end

  // ==========================================================================
  // Data value bank.
  budget_value_bank u_bank (
    .clk_sys_in   (clk_sys_in),
    .resetn_in    (resetn_in),
    .write_in     (value_write),
    .select_in    (select_q),
    .readback_out (readback)
  );

  // ==========================================================================
  // Outputs.
  assign hrdata_out             = hrdata_q;
  assign hreadyout_out          = 1'b1;
  assign hresp_out              = HRESP_OKAY;
  assign system_allocated_out   = allocated_q;
  assign capability_present_out = present_q;

endmodule : power_budget_capability_regs
`default_nettype wire

// [bench/budget_regs_sva.sv]
// Checker of bus answers and capability behaviour of the budget register bank.
`default_nettype none
module budget_regs_sva
  import budget_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        resetn_in,
  input wire logic        hot_reset_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [2:0]  hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic        serial_load_valid_in,
  input wire logic [11:0] serial_load_offset_in,
  input wire logic [31:0] serial_load_data_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic [1:0]  hresp_out,
  input wire logic        system_allocated_out,
  input wire logic        capability_present_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Bus phase mirrors; the select copy lets read-back zeros be judged.
  logic        rd_take;
  logic        wr_q;
  logic [11:0] wa_q;
  logic [7:0]  sel_q;
  assign rd_take = hsel_in & htrans_in[1] & hready_in & !hwrite_in;
  always_ff @(posedge clk_sys_in)
  begin
    wr_q <= resetn_in & hsel_in & htrans_in[1] & hready_in & hwrite_in;
    wa_q <= haddr_in[11:0];
    if (!resetn_in || hot_reset_in)
      sel_q <= SELECT_RESET;
    else if (serial_load_valid_in && serial_load_offset_in == OFFSET_SELECT)
      sel_q <= serial_load_data_in[7:0];
    else if (wr_q && hready_in && wa_q == OFFSET_SELECT)
      sel_q <= hwdata_in[7:0];
  end
  // ==========================================================================
  // Properties.
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  sequence s_hdr_load;
    serial_load_valid_in && !hot_reset_in && serial_load_offset_in == OFFSET_HEADER
      && serial_load_data_in[19:0] == {CAP_VERSION_ONE, CAP_ID_POWER};
  endsequence
  sequence s_quiet;
    !serial_load_valid_in && !hot_reset_in && !wr_q;
  endsequence
  a_header_sets_present: assert property (
    s_hdr_load ##1 s_quiet |=> capability_present_out)
    else $error("present flag missing after header load");
  a_hot_clears_present: assert property (hot_reset_in |-> ##2 !capability_present_out)
    else $error("present flag kept after hot reset");
  a_reset_present_low: assert property (disable iff (1'b0)
    !resetn_in |=> !capability_present_out)
    else $error("present flag high after reset");
  a_reset_flag_low: assert property (disable iff (1'b0)
    !resetn_in |=> !system_allocated_out)
    else $error("allocated flag high after reset");
  a_flag_change_cause: assert property ($changed(system_allocated_out) |->
    $past(serial_load_valid_in) || $past(wr_q) || !$past(resetn_in))
    else $error("allocated flag changed without a write");
  a_select_reads_back: assert property (rd_take && haddr_in[11:0] == OFFSET_SELECT
    |=> hrdata_out == {24'h000000, $past(sel_q)}) else $error("select read wrong");
  a_high_select_zero: assert property (rd_take && haddr_in[11:0] == OFFSET_READBACK
    && sel_q > VALUE_LAST_INDEX |=> hrdata_out == READ_ZERO) else $error("readback not zero");
  a_window_reads_zero: assert property (rd_take && haddr_in[11:0] >= OFFSET_VALUE_BASE
    |=> hrdata_out == READ_ZERO) else $error("value window read not zero");
  a_read_data_holds: assert property (!rd_take |=> $stable(hrdata_out))
    else $error("read data moved without a read");
  a_bus_always_okay: assert property (hreadyout_out && hresp_out == HRESP_OKAY)
    else $error("bus answer not ready and okay");
endmodule : budget_regs_sva
bind power_budget_capability_regs budget_regs_sva u_chk (.clk_sys_in(clk_sys_in),
  .resetn_in(resetn_in), .hot_reset_in(hot_reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .serial_load_valid_in(serial_load_valid_in),
  .serial_load_offset_in(serial_load_offset_in), .serial_load_data_in(serial_load_data_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .system_allocated_out(system_allocated_out), .capability_present_out(capability_present_out));
`default_nettype wire

// [bench/power_budget_capability_regs_tb_top.sv]
// Self-checking bench of the power budget register bank.
`default_nettype none
module power_budget_capability_regs_tb_top
  import budget_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, hot = 1'b0, hsel = 1'b0, hwrite = 1'b0, sl_v = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [11:0] sl_off = 12'h000;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, sl_data = 32'h0, rd;
  logic [31:0] hrdata;
  logic [1:0]  hresp;
  logic        hrdy, sa, present;
  int          error_cnt = 0, num_checks = 0;
  always #2 clk = ~clk;
  power_budget_capability_regs dut (.clk_sys_in(clk), .resetn_in(rst_n), .hot_reset_in(hot),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .serial_load_valid_in(sl_v),
    .serial_load_offset_in(sl_off), .serial_load_data_in(sl_data), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp), .system_allocated_out(sa),
    .capability_present_out(present));
  // ==========================================================================
  // Shared tasks.
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Waits are bounded so a stuck slave ends the run instead of hanging it.
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hrdy !== 1'b1)
    begin
      n++;
      if (n > 64)
      begin
        error_cnt++;
        summarize();
      end
      @(posedge clk);
    end
  endtask : wait_rdy
  task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    check(n, rd, e);
  endtask : rchk
  // ==========================================================================
  // Scenarios.
  task automatic t_reset_values;
    rchk("header", OFFSET_HEADER, HEADER_RESET);
    rchk("select", OFFSET_SELECT, {24'h0, SELECT_RESET});
    rchk("readback", OFFSET_READBACK, READ_ZERO);
    rchk("flags", OFFSET_FLAGS, READ_ZERO);
    rchk("value window", OFFSET_VALUE_BASE, READ_ZERO);
    xfer(OFFSET_HEADER, 1'b1, 32'h0001_0004);
    xfer(OFFSET_FLAGS, 1'b1, 32'h0000_0001);
    rchk("locked header", OFFSET_HEADER, HEADER_RESET);
    check("locked flag", {31'h0, sa}, 32'h0);
  endtask : t_reset_values
  task automatic t_values;
    int sv[14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 31, 32, 255};
    xfer(OFFSET_SYS_CONTROL, 1'b1, 32'h0000_0001);
    for (int i = 0; i < VALUE_COUNT; i++)
      xfer(OFFSET_VALUE_BASE + 12'(4 * i), 1'b1, 32'hA500_0000 + 32'(i));
    xfer(OFFSET_FLAGS, 1'b1, 32'h0000_0001);
    @(posedge clk);
    check("allocated", {31'h0, sa}, 32'h1);
    for (int i = 0; i < 14; i++)
    begin
      xfer(OFFSET_SELECT, 1'b1, 32'hFFFF_FF00 | 32'(sv[i]));
      rchk("select", OFFSET_SELECT, 32'(sv[i]));
      rchk("readback", OFFSET_READBACK,
        (sv[i] <= 9) ? 32'hA500_0000 + 32'(sv[i]) : READ_ZERO);
    end
    // Select a live word first, so a write that leaked into it would show.
    xfer(OFFSET_SELECT, 1'b1, 32'h0000_0000);
    xfer(OFFSET_READBACK, 1'b1, 32'hFFFF_FFFF);
    rchk("readback ro", OFFSET_READBACK, 32'hA500_0000);
  endtask : t_values
  task automatic t_load_hot;
    sl_v <= 1'b1;
    sl_off <= OFFSET_HEADER;
    sl_data <= 32'h0001_0004;
    @(posedge clk);
    sl_v <= 1'b0;
    repeat (2) @(posedge clk);
    check("present", {31'h0, present}, 32'h1);
    rchk("loaded header", OFFSET_HEADER, {12'h0, CAP_VERSION_ONE, CAP_ID_POWER});
    xfer(OFFSET_SELECT, 1'b1, 32'h0000_0003);
    @(posedge clk);
    hot <= 1'b1;
    @(posedge clk);
    hot <= 1'b0;
    repeat (2) @(posedge clk);
    check("present hot", {31'h0, present}, 32'h0);
    check("allocated hot", {31'h0, sa}, 32'h1);
    rchk("header hot", OFFSET_HEADER, HEADER_RESET);
    xfer(OFFSET_FLAGS, 1'b1, 32'h0);
    xfer(OFFSET_VALUE_BASE, 1'b1, 32'h0000_1234);
    rchk("kept value", OFFSET_READBACK, 32'hA500_0000);
    check("allocated locked", {31'h0, sa}, 32'h1);
  endtask : t_load_hot
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset_values();
    t_values();
    @(posedge clk);
    t_load_hot();
    summarize();
  end
endmodule : power_budget_capability_regs_tb_top
`default_nettype wire
